// ---- verilog/fisr_pkg.sv ----
// Package: register map and field positions for fault event and sense regs
package fisr_pkg;
  localparam logic [7:0] EVENT_LATCH_THREE_ADDR = 8'h03;
  localparam logic [7:0] LIVE_CONDITION_ONE_ADDR = 8'h04;
  localparam logic [7:0] EVENT_LATCH_THREE_RST = 8'h00;
  localparam logic [7:0] LIVE_CONDITION_ONE_RST = 8'h00;
  // Event register three bit positions
  localparam int EV_TIMEOUT = 0;
  localparam int EV_INDICATOR = 1;
  localparam int EV_PIN_TWO = 2;
  localparam int EV_PIN_ONE = 3;
  localparam int EV_TEMP_WARN = 4;
  localparam int EV_THERM_SHDN = 5;
  localparam int EV_AMP_OT = 6;
  localparam int EV_BROWNOUT = 7;
  // Live condition register one bit positions
  localparam int LC_CLOCK_INV = 1;
  localparam int LC_BUCK_LIM = 2;
  localparam int LC_REG_LIM = 3;
  localparam int LC_BOOST_OV = 4;
  localparam int LC_BOOST_LIM = 5;
  localparam int LC_BOOST_GOOD = 6;
  localparam int LC_AMP_OC = 7;
endpackage : fisr_pkg

// ---- verilog/fisr_edge.sv ----
// Edge detector bank: per-bit rising and falling event pulses
`timescale 1ns/1ps
module fisr_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Levels and events
  input wire logic [7:0] level,
  output logic [7:0] rise,
  output logic [7:0] fall
);
  logic [7:0] prev_q;
  logic [7:0] prev_d;

  always_comb begin
    prev_d = level;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= 8'h00;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
endmodule : fisr_edge

// ---- verilog/fisr_top.sv ----
// Third event latch register, first live sense register and interrupt pin
//
// Function
// R1: Unmasked set event bit drives interrupt low
// R2: Indicator fault event on either sense edge
// R3: Pin events on both edges, input mode only
// R4: Amp over-temperature event on both edges
// R5: Buck limit sense one while reached
// R6: Regulator limit sense one while reached
// R7: Boost good sense one when on target
// R8: Sense register read-only, live, zero after reset
// R9: Buck limit event on either sense edge
// R10: Boost good event on rising edge only
// R11: Reading event register returns then clears it
`timescale 1ns/1ps
module fisr_top
  import fisr_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Register read port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Live conditions from analog and pin logic
  input wire logic TIMEOUT_SENSE,
  input wire logic INDICATOR_FAULT_SENSE,
  input wire logic PIN_ONE_SENSE,
  input wire logic PIN_TWO_SENSE,
  input wire logic PIN_ONE_IS_INPUT,
  input wire logic PIN_TWO_IS_INPUT,
  input wire logic TEMP_WARNING_SENSE,
  input wire logic THERMAL_SHUTDOWN_SENSE,
  input wire logic AMP_OVERTEMP_SENSE,
  input wire logic BUCK_BROWNOUT_SENSE,
  input wire logic CLOCK_INVALID_SENSE,
  input wire logic BUCK_LIMIT_SENSE,
  input wire logic REGULATOR_LIMIT_SENSE,
  input wire logic BOOST_OV_SENSE,
  input wire logic BOOST_LIMIT_SENSE,
  input wire logic BOOST_GOOD_SENSE,
  input wire logic AMP_OVERCURRENT_SENSE,
  // Mask for event register three, one masks the bit
  input wire logic [7:0] EVENT_MASK_THREE,
  // Event outputs toward the first event register
  output logic BUCK_LIMIT_EVENT,
  output logic BOOST_GOOD_EVENT,
  // Interrupt pin, active low
  output logic IRQ_OUT_N
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] sense_q;
  logic [7:0] sense_d;
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_n_q;
  logic irq_n_d;
  logic buck_ev_q;
  logic buck_ev_d;
  logic boost_ev_q;
  logic boost_ev_d;
  logic [7:0] ev_level;
  logic [7:0] ev_rise;
  logic [7:0] ev_fall;
  logic [7:0] lc_rise;
  logic [7:0] lc_fall;
  logic [7:0] ev_set;
  logic rd_latch;
  logic rd_sense;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Read strobe aimed at one register
  function automatic logic addr_hit(
    input logic rd,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    addr_hit = rd && (addr == target);
  endfunction : addr_hit

  // Either edge of one bit of a detector bank
  function automatic logic any_edge(
    input logic [7:0] rise,
    input logic [7:0] fall,
    input int idx
  );
    any_edge = rise[idx] | fall[idx];
  endfunction : any_edge

  ////////////////////////////////////////////////////////////////////////////
  // Live sense register capture
  always_comb begin
    sense_d = 8'h00;
    sense_d[LC_CLOCK_INV] = CLOCK_INVALID_SENSE;
    sense_d[LC_BUCK_LIM] = BUCK_LIMIT_SENSE; // R5
    sense_d[LC_REG_LIM] = REGULATOR_LIMIT_SENSE; // R6
    sense_d[LC_BOOST_OV] = BOOST_OV_SENSE;
    sense_d[LC_BOOST_LIM] = BOOST_LIMIT_SENSE;
    sense_d[LC_BOOST_GOOD] = BOOST_GOOD_SENSE; // R7
    sense_d[LC_AMP_OC] = AMP_OVERCURRENT_SENSE;
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sense_q <= LIVE_CONDITION_ONE_RST; // R8
    end else begin
      sense_q <= sense_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on event levels and on sense bits
  always_comb begin
    ev_level = 8'h00;
    ev_level[EV_TIMEOUT] = TIMEOUT_SENSE;
    ev_level[EV_INDICATOR] = INDICATOR_FAULT_SENSE;
    ev_level[EV_PIN_TWO] = PIN_TWO_SENSE;
    ev_level[EV_PIN_ONE] = PIN_ONE_SENSE;
    ev_level[EV_TEMP_WARN] = TEMP_WARNING_SENSE;
    ev_level[EV_THERM_SHDN] = THERMAL_SHUTDOWN_SENSE;
    ev_level[EV_AMP_OT] = AMP_OVERTEMP_SENSE;
    ev_level[EV_BROWNOUT] = BUCK_BROWNOUT_SENSE;
  end

  fisr_edge u_ev_edge (
    .clk(MCLK),
    .rst(SYS_RST),
    .level(ev_level),
    .rise(ev_rise),
    .fall(ev_fall)
  );

  fisr_edge u_lc_edge (
    .clk(MCLK),
    .rst(SYS_RST),
    .level(sense_q),
    .rise(lc_rise),
    .fall(lc_fall)
  );

  always_comb begin
    ev_set = ev_rise | ev_fall;
    ev_set[EV_TIMEOUT] = ev_rise[EV_TIMEOUT];
    ev_set[EV_INDICATOR] = any_edge(ev_rise, ev_fall, EV_INDICATOR); // R2
    ev_set[EV_PIN_ONE] = PIN_ONE_IS_INPUT
      & any_edge(ev_rise, ev_fall, EV_PIN_ONE); // R3
    ev_set[EV_PIN_TWO] = PIN_TWO_IS_INPUT
      & any_edge(ev_rise, ev_fall, EV_PIN_TWO); // R3
    ev_set[EV_AMP_OT] = any_edge(ev_rise, ev_fall, EV_AMP_OT); // R4
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read, latch and clear
  assign rd_latch = addr_hit(REG_RD, REG_ADDR, EVENT_LATCH_THREE_ADDR);
  assign rd_sense = addr_hit(REG_RD, REG_ADDR, LIVE_CONDITION_ONE_ADDR);

  // Read data holds the last value returned
  always_comb begin
    rdata_d = rdata_q;
    if (rd_latch) begin
      rdata_d = latch_q; // R11
    end else if (rd_sense) begin
      rdata_d = sense_q; // R8
    end else if (REG_RD) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event latch; new events win over the read clear
  always_comb begin
    if (rd_latch) begin
      latch_d = ev_set; // R11
    end else begin
      latch_d = latch_q | ev_set;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      latch_q <= EVENT_LATCH_THREE_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin follows the next latch value
  always_comb begin
    irq_n_d = ~|(latch_d & ~EVENT_MASK_THREE); // R1
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_n_q <= 1'h1;
    end else begin
      irq_n_q <= irq_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulses toward the first event register
  always_comb begin
    buck_ev_d = any_edge(lc_rise, lc_fall, LC_BUCK_LIM); // R9
    boost_ev_d = lc_rise[LC_BOOST_GOOD]; // R10
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      buck_ev_q <= 1'h0;
      boost_ev_q <= 1'h0;
    end else begin
      buck_ev_q <= buck_ev_d;
      boost_ev_q <= boost_ev_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign IRQ_OUT_N = irq_n_q;
  assign BUCK_LIMIT_EVENT = buck_ev_q;
  assign BOOST_GOOD_EVENT = boost_ev_q;
endmodule : fisr_top

// ---- bench/fisr_host.sv ----
// Partner model: control processor issuing register reads
`timescale 1ns/1ps
module fisr_host (
  // Clock
  input wire logic MCLK,
  // Read port
  output logic REG_RD,
  output logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA
);
  initial begin
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
  end
  // One read; strobe held for one cycle, data sampled one cycle later
  task rd(input logic [7:0] a, output logic [7:0] d);
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(posedge MCLK);
    #1 REG_RD = 1'b0;
    REG_ADDR = ~a;
    @(posedge MCLK);
    #1 d = REG_RDATA;
  endtask : rd
endmodule : fisr_host

// ---- bench/fisr_props.sv ----
// Checker: port timing of the event latch and sense block
`timescale 1ns/1ps
module fisr_props (
  // Clock, reset, read port
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  // Sensed levels and mask
  input wire logic INDICATOR_FAULT_SENSE,
  input wire logic PIN_ONE_SENSE,
  input wire logic PIN_ONE_IS_INPUT,
  input wire logic AMP_OVERTEMP_SENSE,
  input wire logic BUCK_LIMIT_SENSE,
  input wire logic BOOST_GOOD_SENSE,
  input wire logic [7:0] EVENT_MASK_THREE,
  // Outputs
  input wire logic BUCK_LIMIT_EVENT,
  input wire logic BOOST_GOOD_EVENT,
  input wire logic IRQ_OUT_N
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  property p_ind; $changed(INDICATOR_FAULT_SENSE) && !EVENT_MASK_THREE[1]
    ##0 !REG_RD [*3] |-> !IRQ_OUT_N; endproperty
  a_ind: assert property (p_ind)
    else $error("no irq on indicator edge");
  property p_pin; $changed(PIN_ONE_SENSE) && PIN_ONE_IS_INPUT &&
    !EVENT_MASK_THREE[3] ##0 !REG_RD [*3] |-> !IRQ_OUT_N; endproperty
  a_pin: assert property (p_pin)
    else $error("no irq on pin edge");
  property p_amp; $changed(AMP_OVERTEMP_SENSE) && !EVENT_MASK_THREE[6]
    ##0 !REG_RD [*3] |-> !IRQ_OUT_N; endproperty
  a_amp: assert property (p_amp)
    else $error("no irq on amp edge");
  property p_buck; $changed(BUCK_LIMIT_SENSE) |-> ##[1:3] BUCK_LIMIT_EVENT;
  endproperty
  a_buck: assert property (p_buck) else $error("buck event missing");
  property p_buck_src; BUCK_LIMIT_EVENT |->
    $past(BUCK_LIMIT_SENSE, 2) != $past(BUCK_LIMIT_SENSE, 3) ||
    $past(SYS_RST, 3); endproperty
  a_buck_src: assert property (p_buck_src)
    else $error("buck event without edge");
  property p_bg_rise; $rose(BOOST_GOOD_SENSE) |-> ##[1:3] BOOST_GOOD_EVENT;
  endproperty
  a_bg_rise: assert property (p_bg_rise) else $error("good event miss");
  property p_bg_fall; BOOST_GOOD_EVENT |-> $past(BOOST_GOOD_SENSE, 2) &&
    (!$past(BOOST_GOOD_SENSE, 3) || $past(SYS_RST, 3)); endproperty
  a_bg_fall: assert property (p_bg_fall) else $error("good event bad");
  property p_buck_rd; REG_RD && REG_ADDR == 8'h04 && !$past(SYS_RST) &&
    $stable(BUCK_LIMIT_SENSE) |=> REG_RDATA[2] == $past(BUCK_LIMIT_SENSE);
  endproperty
  a_buck_rd: assert property (p_buck_rd) else $error("buck sense bad");
  property p_bit0; REG_RD && REG_ADDR == 8'h04 |=> !REG_RDATA[0]; endproperty
  a_bit0: assert property (p_bit0) else $error("sense bit0 set");
endmodule : fisr_props
bind fisr_top fisr_props u_props (.*);

// ---- bench/tb_fisr_top.sv ----
// Testbench: event latch three, live sense one and interrupt pin
`timescale 1ns/1ps
module tb_fisr_top;
  logic MCLK = 0, SYS_RST = 1, TIMEOUT_SENSE = 0, INDICATOR_FAULT_SENSE = 0;
  logic PIN_ONE_SENSE = 0, PIN_TWO_SENSE = 0, PIN_ONE_IS_INPUT = 0;
  logic PIN_TWO_IS_INPUT = 0, TEMP_WARNING_SENSE = 0, AMP_OVERTEMP_SENSE = 0;
  logic THERMAL_SHUTDOWN_SENSE = 0, BUCK_BROWNOUT_SENSE = 0, BOOST_OV_SENSE = 0;
  logic CLOCK_INVALID_SENSE = 0, BUCK_LIMIT_SENSE = 0, BOOST_LIMIT_SENSE = 0;
  logic REGULATOR_LIMIT_SENSE = 0, BOOST_GOOD_SENSE = 0;
  logic AMP_OVERCURRENT_SENSE = 0;
  logic [7:0] EVENT_MASK_THREE = 8'h00;
  wire REG_RD, IRQ_OUT_N, BUCK_LIMIT_EVENT, BOOST_GOOD_EVENT;
  wire [7:0] REG_ADDR, REG_RDATA;
  int n_fail = 0, compares = 0;
  fisr_top uut (.*);
  fisr_host host (.*);
  initial begin
    forever #12.5 MCLK = ~MCLK;
  end
  task step(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : step
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task rd_chk(input logic [7:0] a, e, input string s);
    logic [7:0] d;
    host.rd(a, d);
    chk(s, e, d);
  endtask : rd_chk
  task set_ev(input logic [7:0] v);
    {BUCK_BROWNOUT_SENSE, AMP_OVERTEMP_SENSE, THERMAL_SHUTDOWN_SENSE,
     TEMP_WARNING_SENSE, PIN_ONE_SENSE, PIN_TWO_SENSE,
     INDICATOR_FAULT_SENSE, TIMEOUT_SENSE} = v;
    step(4);
  endtask : set_ev
  task cnt_pulse(input int n, output logic [7:0] nb, output logic [7:0] ng);
    nb = 8'h00;
    ng = 8'h00;
    repeat (n) begin
      @(posedge MCLK);
      #1;
      nb = nb + {7'h00, BUCK_LIMIT_EVENT};
      ng = ng + {7'h00, BOOST_GOOD_EVENT};
    end
  endtask : cnt_pulse
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd_chk(8'h04, 8'h00, "sense");
    rd_chk(8'h03, 8'h00, "events");
    chk("irq", 8'h01, {7'h00, IRQ_OUT_N});
    $display("t_reset done");
  endtask : t_reset
  task t_edges;
    {PIN_ONE_IS_INPUT, PIN_TWO_IS_INPUT} = 2'b10;
    set_ev(8'hFF);
    chk("irq", 8'h00, {7'h00, IRQ_OUT_N});
    rd_chk(8'h03, 8'hFB, "rise");
    rd_chk(8'h03, 8'h00, "cleared");
    chk("irq", 8'h01, {7'h00, IRQ_OUT_N});
    set_ev(8'h00);
    rd_chk(8'h03, 8'hFA, "fall");
    $display("t_edges done");
  endtask : t_edges
  task t_mask;
    EVENT_MASK_THREE = 8'hFF;
    AMP_OVERTEMP_SENSE = 1'b1;
    step(4);
    chk("masked irq", 8'h01, {7'h00, IRQ_OUT_N});
    EVENT_MASK_THREE = 8'h00;
    step(2);
    chk("unmasked irq", 8'h00, {7'h00, IRQ_OUT_N});
    AMP_OVERTEMP_SENSE = 1'b0;
    step(4);
    rd_chk(8'h03, 8'h40, "amp");
    $display("t_mask done");
  endtask : t_mask
  task t_sense;
    {AMP_OVERCURRENT_SENSE, BOOST_GOOD_SENSE, BOOST_LIMIT_SENSE, BOOST_OV_SENSE,
     REGULATOR_LIMIT_SENSE, BUCK_LIMIT_SENSE, CLOCK_INVALID_SENSE} = 7'h7F;
    step(3);
    rd_chk(8'h04, 8'hFE, "sense on");
    {BOOST_GOOD_SENSE, REGULATOR_LIMIT_SENSE, BUCK_LIMIT_SENSE} = 3'h0;
    step(3);
    rd_chk(8'h04, 8'hB2, "sense off");
    rd_chk(8'h10, 8'h00, "unmapped");
    $display("t_sense done");
  endtask : t_sense
  task t_pins;
    {PIN_ONE_IS_INPUT, PIN_TWO_IS_INPUT} = 2'h1;
    set_ev(8'h0C);
    rd_chk(8'h03, 8'h04, "pin two rise");
    set_ev(8'h00);
    rd_chk(8'h03, 8'h04, "pin two fall");
    $display("t_pins done");
  endtask : t_pins
  task t_race;
    TIMEOUT_SENSE = 1'h1;
    rd_chk(8'h03, 8'h00, "race read");
    rd_chk(8'h03, 8'h01, "race kept");
    TIMEOUT_SENSE = 1'h0;
    step(2);
    chk("irq after race", 8'h01, {7'h00, IRQ_OUT_N});
    $display("t_race done");
  endtask : t_race
  task t_pulse;
    logic [7:0] nb, ng;
    BUCK_LIMIT_SENSE = 1'h1;
    BOOST_GOOD_SENSE = 1'h1;
    cnt_pulse(6, nb, ng);
    chk("buck rise pulses", 8'h01, nb);
    chk("good rise pulses", 8'h01, ng);
    BUCK_LIMIT_SENSE = 1'h0;
    BOOST_GOOD_SENSE = 1'h0;
    cnt_pulse(6, nb, ng);
    chk("buck fall pulses", 8'h01, nb);
    chk("good fall pulses", 8'h00, ng);
    $display("t_pulse done");
  endtask : t_pulse
  task t_rerst;
    set_ev(8'h80);
    set_ev(8'h00);
    chk("irq before reset", 8'h00, {7'h00, IRQ_OUT_N});
    SYS_RST = 1'h1;
    step(2);
    SYS_RST = 1'h0;
    chk("irq after reset", 8'h01, {7'h00, IRQ_OUT_N});
    rd_chk(8'h04, 8'h00, "sense after reset");
    rd_chk(8'h03, 8'h00, "events after reset");
    $display("t_rerst done");
  endtask : t_rerst
  task wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    step(20);
    SYS_RST = 1'b0;
    t_reset();
    t_edges();
    t_pins();
    t_race();
    t_mask();
    t_sense();
    t_pulse();
    t_rerst();
    wrap_up();
  end
endmodule : tb_fisr_top
